// ===== hw/amp_ctrl_consts.vh
`ifndef AMP_CTRL_CONSTS_VH
`define AMP_CTRL_CONSTS_VH

// Wishbone register byte addresses of the controller
`define ADDR_CTRL        4'h0
`define ADDR_STATUS      4'h4
`define ADDR_WORD        4'h8
`define ADDR_PAR         4'hC
`define ADDR_BITS        4

// Control register fields
`define CTRL_START_BIT   0
`define CTRL_MODE_BIT    1
`define CTRL_CHAIN_LSB   8
`define CTRL_CHAIN_W     4
`define CTRL_HALF_LSB    16
`define CTRL_HALF_W      8
`define CTRL_RESET       32'h00000000

// Status register fields
`define STAT_BUSY_BIT    0
`define STAT_MODE_BIT    1
`define STAT_DONE_BIT    2

// Parallel register fields
`define PAR_GAIN_LSB     0
`define PAR_GAIN_W       3
`define PAR_PD_BIT       4

// Amplifier control word layout
`define WORD_W           16
`define WORD_GAIN_LSB    0
`define WORD_COMP_LSB    3
`define WORD_ROUTE_LSB   6
`define WORD_SWAP_BIT    8
`define WORD_POWER_DOWN_REQ_BIT    9
`define WORD_EXT_CAP_FILTER_EN_BIT    10
`define WORD_PIN_BIT     11
`define WORD_CUR_LSB     12
`define WORD_SPARE_BIT   15
`define WORD_RESET       16'h0000
`define WORD_LAST_IDX    4'hF

// Serial clock half period, minus one, in system clocks
`define HALF_DEFAULT     8'h04
`define HALF_MIN         8'h01

`endif

// ===== hw/word_store.v
`timescale 1ns/1ns
// Small memory holding the words of one daisy chain frame
module word_store #(
  parameter DEPTH = 16,
  parameter AW    = 4,
  parameter DW    = 16
) (
  // Clock
  input  wire          i_clock,
  // Write port
  input  wire          i_we,
  input  wire [AW-1:0] i_waddr,
  input  wire [DW-1:0] i_wdata,
  // Read port
  input  wire [AW-1:0] i_raddr,
  output reg  [DW-1:0] o_rdata
);

  reg [DW-1:0] mem [0:DEPTH-1];

  always @(posedge i_clock) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
    o_rdata <= mem[i_raddr];
  end

endmodule

// ===== hw/amp_host_ctrl.v
`timescale 1ns/1ns
// Operation
// - Bits 12-14 fault current; bit 15 always written zero.
// - Host shifts exactly sixteen bits per word.
// - Serial clock stays high at both select edges.
// - Host writes the control word right after power-on; here nothing is sent until software writes the start bit.
// - Shared select loads all devices alike; separate selects load them apart.
// - Daisy chain: data out feeds next device data in.
// - In a chain first word sent ends up in the last device.
`include "amp_ctrl_consts.vh"
module amp_host_ctrl #(
  parameter CHAIN_MAX = 16,
  parameter CHAIN_AW  = 4
) (
  // Clock and reset
  input  wire        i_clock,
  input  wire        i_rst_b,
  // Wishbone slave
  input  wire        i_wb_cyc,
  input  wire        i_wb_stb,
  input  wire        i_wb_we,
  input  wire [3:0]  i_wb_adr,
  input  wire [3:0]  i_wb_sel,
  input  wire [31:0] i_wb_dat,
  output reg  [31:0] o_wb_dat,
  output reg         o_wb_ack,
  // Mode reference levels
  output reg         o_mode_ref_a,
  output reg         o_mode_ref_b,
  // Serial link
  output reg         o_sclk,
  output reg         o_sdata,
  output reg         o_chip_select_n,
  input  wire        i_sdata_ret,
  // Parallel pins
  output reg         o_gain_sel_lsb,
  output reg         o_gain_sel_mid,
  output reg         o_gain_sel_msb,
  output reg         o_power_down_req
);

  localparam ST_IDLE  = 3'h0;
  localparam ST_FETCH = 3'h1;
  localparam ST_LOAD  = 3'h2;
  localparam ST_LOW   = 3'h3;
  localparam ST_HIGH  = 3'h4;
  localparam ST_END   = 3'h5;
  localparam ST_CSUP  = 3'h6;

  // Software registers
  reg                      serial_mode_r;
  reg [`CTRL_CHAIN_W-1:0]  chain_last_r;
  reg [`CTRL_HALF_W-1:0]   half_r;
  reg [`PAR_GAIN_W-1:0]    par_gain_r;
  reg                      par_pd_r;
  reg                      done_r;
  reg [`WORD_W-1:0]        echo_r;
  // Engine
  reg [2:0]                state_r;
  reg [CHAIN_AW-1:0]       word_idx_r;
  reg [3:0]                bit_cnt_r;
  reg [`CTRL_HALF_W-1:0]   tick_r;
  reg [`WORD_W-1:0]        shift_r;
  reg                      ret_meta_r;
  reg                      ret_sync_r;

  wire [`WORD_W-1:0] store_rdata;
  wire               wb_req  = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  wire               wb_wr   = i_wb_cyc & i_wb_stb & i_wb_we & o_wb_ack;
  wire               busy    = (state_r != ST_IDLE);
  wire               hit_w   = wb_wr & (i_wb_adr == `ADDR_WORD) & (&i_wb_sel[1:0]);
  // Serial mode out of reset, so software can load the amplifier on its first write
  wire               start   = wb_wr & (i_wb_adr == `ADDR_CTRL) & i_wb_sel[0]
                               & i_wb_dat[`CTRL_START_BIT] & ~busy & serial_mode_r;
  wire               tick_dn = (tick_r == {`CTRL_HALF_W{1'b0}});

  // Spare bit forced low whatever software writes
  function [`WORD_W-1:0] clean_word;
    input [`WORD_W-1:0] w;
    begin
      clean_word = w & ~(16'h0001 << `WORD_SPARE_BIT);
    end
  endfunction

  function [`CTRL_HALF_W-1:0] half_sat;
    input [`CTRL_HALF_W-1:0] h;
    begin
      half_sat = (h < `HALF_MIN) ? `HALF_MIN : h;
    end
  endfunction

  word_store #(
    .DEPTH (CHAIN_MAX),
    .AW    (CHAIN_AW),
    .DW    (`WORD_W)
  ) u_store (
    .i_clock (i_clock),
    .i_we    (hit_w),
    .i_waddr (i_wb_dat[`WORD_W+CHAIN_AW-1:`WORD_W]),
    .i_wdata (clean_word(i_wb_dat[`WORD_W-1:0])),
    .i_raddr (word_idx_r),
    .o_rdata (store_rdata)
  );

  // Bus slave: ack one cycle after request; writes commit on the edge that sees ack high
  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_wb_ack      <= 1'b0;
      o_wb_dat      <= 32'h00000000;
      serial_mode_r <= 1'b1;
      chain_last_r  <= {`CTRL_CHAIN_W{1'b0}};
      half_r        <= `HALF_DEFAULT;
      par_gain_r    <= {`PAR_GAIN_W{1'b0}};
      par_pd_r      <= 1'b0;
    end else begin
      o_wb_ack <= wb_req;
      o_wb_dat <= 32'h00000000;
      if (wb_req && !i_wb_we) begin
        case (i_wb_adr)
          `ADDR_CTRL: begin
            o_wb_dat <= {8'h00, half_r, 4'h0, chain_last_r, 6'h00, serial_mode_r, 1'b0};
          end
          `ADDR_STATUS: begin
            o_wb_dat <= {29'h00000000, done_r, serial_mode_r, busy};
          end
          `ADDR_WORD: begin
            o_wb_dat <= {16'h0000, echo_r};
          end
          `ADDR_PAR: begin
            o_wb_dat <= {27'h0000000, par_pd_r, 1'b0, par_gain_r};
          end
          default: begin
            o_wb_dat <= 32'h00000000;
          end
        endcase
      end
      // Mode and chain length are frozen during a frame
      if (wb_wr && i_wb_adr == `ADDR_CTRL && !busy) begin
        if (i_wb_sel[0]) begin
          serial_mode_r <= i_wb_dat[`CTRL_MODE_BIT];
        end
        if (i_wb_sel[1]) begin
          chain_last_r <= i_wb_dat[`CTRL_CHAIN_LSB+`CTRL_CHAIN_W-1:`CTRL_CHAIN_LSB];
        end
        if (i_wb_sel[2]) begin
          half_r <= half_sat(i_wb_dat[`CTRL_HALF_LSB+`CTRL_HALF_W-1:`CTRL_HALF_LSB]);
        end
      end
      if (wb_wr && i_wb_adr == `ADDR_PAR && i_wb_sel[0]) begin
        par_gain_r <= i_wb_dat[`PAR_GAIN_LSB+`PAR_GAIN_W-1:`PAR_GAIN_LSB];
        par_pd_r   <= i_wb_dat[`PAR_PD_BIT];
      end
    end
  end

  // Mode pins and parallel pins
  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_mode_ref_a     <= 1'b0;
      o_mode_ref_b     <= 1'b1;
      o_gain_sel_lsb   <= 1'b0;
      o_gain_sel_mid   <= 1'b0;
      o_gain_sel_msb   <= 1'b0;
      o_power_down_req <= 1'b0;
    end else begin
      o_mode_ref_a <= ~serial_mode_r;
      o_mode_ref_b <= serial_mode_r;
      // Parallel pins are shared with the serial link on the device, so park them in serial mode
      if (serial_mode_r) begin
        o_gain_sel_lsb   <= 1'b0;
        o_gain_sel_mid   <= 1'b0;
        o_gain_sel_msb   <= 1'b0;
        o_power_down_req <= 1'b0;
      end else begin
        o_gain_sel_msb   <= par_gain_r[2];
        o_gain_sel_mid   <= par_gain_r[1];
        o_gain_sel_lsb   <= par_gain_r[0];
        o_power_down_req <= par_pd_r;
      end
    end
  end

  // Returned chain data crosses in via two flops
  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ret_meta_r <= 1'b0;
      ret_sync_r <= 1'b0;
    end else begin
      ret_meta_r <= i_sdata_ret;
      ret_sync_r <= ret_meta_r;
    end
  end

  // Serial engine: words 0..chain_last sent in index order, first ends in last device
  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_r         <= ST_IDLE;
      word_idx_r      <= {CHAIN_AW{1'b0}};
      bit_cnt_r       <= 4'h0;
      tick_r          <= {`CTRL_HALF_W{1'b0}};
      shift_r         <= `WORD_RESET;
      echo_r          <= `WORD_RESET;
      done_r          <= 1'b0;
      o_sclk          <= 1'b1;
      o_sdata         <= 1'b0;
      o_chip_select_n <= 1'b1;
    end else begin
      if (!tick_dn) begin
        tick_r <= tick_r - 1'b1;
      end
      case (state_r)
        ST_IDLE: begin
          o_sclk <= 1'b1;
          if (start) begin
            done_r     <= 1'b0;
            word_idx_r <= {CHAIN_AW{1'b0}};
            state_r    <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          state_r <= ST_LOAD;
        end
        ST_LOAD: begin
          shift_r   <= store_rdata;
          bit_cnt_r <= `WORD_LAST_IDX;
          tick_r    <= half_r;
          // Select falls while clock is high; one select line serves every chained device
          o_chip_select_n <= 1'b0;
          state_r         <= ST_LOW;
        end
        ST_LOW: begin
          if (tick_dn) begin
            o_sclk  <= 1'b0;
            o_sdata <= shift_r[`WORD_W-1];
            tick_r  <= half_r;
            state_r <= ST_HIGH;
          end
        end
        ST_HIGH: begin
          if (tick_dn) begin
            // Device samples on this rise
            o_sclk  <= 1'b1;
            shift_r <= {shift_r[`WORD_W-2:0], ret_sync_r};
            tick_r  <= half_r;
            if (bit_cnt_r == 4'h0) begin
              state_r <= ST_END;
            end else begin
              bit_cnt_r <= bit_cnt_r - 1'b1;
              state_r   <= ST_LOW;
            end
          end
        end
        ST_END: begin
          if (tick_dn) begin
            if (word_idx_r == chain_last_r[CHAIN_AW-1:0]) begin
              // Rise of select latches the word with clock still high
              o_chip_select_n <= 1'b1;
              echo_r          <= shift_r;
              tick_r          <= half_r;
              state_r         <= ST_CSUP;
            end else begin
              word_idx_r <= word_idx_r + 1'b1;
              state_r    <= ST_FETCH;
            end
          end
        end
        ST_CSUP: begin
          // Deselect gap before another frame may begin
          if (tick_dn) begin
            done_r  <= 1'b1;
            state_r <= ST_IDLE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

// ===== bench/amp_dev_model.sv
`timescale 1ns/1ns
module amp_dev_model (
  // Serial pins
  input  wire        i_sclk,
  input  wire        i_csn,
  input  wire        i_sdi,
  output wire        o_sdo,
  // Active settings
  output reg  [15:0] o_hold
);
  reg [15:0] sh_r = 16'h0000;
  initial o_hold = 16'h0000;
  // Unselected, show the inverse so a stale bit cannot pass for fresh data
  assign o_sdo = i_csn ? ~sh_r[15] : sh_r[15];
  always @(posedge i_sclk) begin
    if (!i_csn)
      sh_r <= {sh_r[14:0], i_sdi};
  end
  always @(posedge i_csn) o_hold <= sh_r;
endmodule

// ===== bench/amp_host_ctrl_assertions.sv
`timescale 1ns/1ns
module amp_ctrl_checker (
  // Clock and reset
  input wire i_clock,
  input wire i_rst_b,
  // Observed outputs
  input wire o_mode_ref_a,
  input wire o_mode_ref_b,
  input wire o_sclk,
  input wire o_sdata,
  input wire o_chip_select_n,
  input wire o_gain_sel_lsb,
  input wire o_gain_sel_mid,
  input wire o_gain_sel_msb,
  input wire o_power_down_req
);
  reg       sclk_q_r;
  reg [8:0] rise_r;
  // Nine bits so a full sixteen-word frame does not wrap to zero
  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sclk_q_r <= 1'b1;
      rise_r <= 9'h000;
    end else begin
      sclk_q_r <= o_sclk;
      if (o_chip_select_n)
        rise_r <= 9'h000;
      else if (o_sclk && !sclk_q_r)
        rise_r <= rise_r + 9'h001;
    end
  end
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);
  property p_mode; o_mode_ref_a != o_mode_ref_b; endproperty
  a_mode: assert property (p_mode) else $error("mode levels equal");
  property p_par; o_mode_ref_a |-> o_chip_select_n; endproperty
  a_par: assert property (p_par) else $error("select in parallel mode");
  property p_pins; !o_mode_ref_a |-> !(o_gain_sel_lsb | o_gain_sel_mid |
    o_gain_sel_msb | o_power_down_req); endproperty
  a_pins: assert property (p_pins) else $error("parallel pins in serial mode");
  property p_csf; $fell(o_chip_select_n) |-> o_sclk && $past(o_sclk); endproperty
  a_csf: assert property (p_csf) else $error("clock low at select fall");
  property p_csr; $rose(o_chip_select_n) |-> o_sclk && $past(o_sclk); endproperty
  a_csr: assert property (p_csr) else $error("clock low at select rise");
  property p_idle; o_chip_select_n |-> o_sclk; endproperty
  a_idle: assert property (p_idle) else $error("clock moves unselected");
  property p_bit; $rose(o_sclk) |-> $stable(o_sdata); endproperty
  a_bit: assert property (p_bit) else $error("data moves at clock rise");
  property p_cnt; $rose(o_chip_select_n) |-> rise_r[3:0] == 4'h0 && rise_r != 9'h000;
  endproperty
  a_cnt: assert property (p_cnt) else $error("partial word in frame");
endmodule
bind amp_host_ctrl amp_ctrl_checker u_chk (.i_clock, .i_rst_b, .o_mode_ref_a, .o_mode_ref_b,
  .o_sclk, .o_sdata, .o_chip_select_n, .o_gain_sel_lsb, .o_gain_sel_mid, .o_gain_sel_msb,
  .o_power_down_req);

// ===== bench/amp_host_ctrl_bench.sv
`timescale 1ns/1ns
module amp_host_ctrl_bench;
  reg         clk = 1'b0;
  reg         rst_b = 1'b0;
  reg         cyc = 1'b0, stb = 1'b0, we = 1'b0;
  reg  [3:0]  adr = 4'h0;
  reg  [31:0] wdat = 32'h00000000;
  wire [31:0] rdat;
  wire        ack, ref_a, ref_b, sclk, sdata, csn, ret, mid_sdo, g0, g1, g2, pd;
  wire [15:0] hold_a, hold_b;
  integer     n_mismatch = 0, cmp_count = 0, seed = 52, i, k;
  reg  [31:0] q, rnd;
  reg  [15:0] m0 = 16'h0000, m1 = 16'h0000, exp_ret;
  reg  [15:0] wv [0:1];
  always #25 clk = ~clk;
  amp_host_ctrl dut (.i_clock(clk), .i_rst_b(rst_b), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(wdat), .o_wb_dat(rdat),
    .o_wb_ack(ack), .o_mode_ref_a(ref_a), .o_mode_ref_b(ref_b), .o_sclk(sclk),
    .o_sdata(sdata), .o_chip_select_n(csn), .i_sdata_ret(ret), .o_gain_sel_lsb(g0),
    .o_gain_sel_mid(g1), .o_gain_sel_msb(g2), .o_power_down_req(pd));
  // Two devices in a chain so displaced words can be followed
  amp_dev_model dev_a (.i_sclk(sclk), .i_csn(csn), .i_sdi(sdata), .o_sdo(mid_sdo),
    .o_hold(hold_a));
  amp_dev_model dev_b (.i_sclk(sclk), .i_csn(csn), .i_sdi(mid_sdo), .o_sdo(ret),
    .o_hold(hold_b));
  task end_of_test;
    if (n_mismatch == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task check(input [31:0] seen, input [31:0] exp);
    cmp_count = cmp_count + 1;
    if (seen !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task wb(input w, input [3:0] a, input [31:0] d);
    integer t;
    begin
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      for (t = 0; t < 20 && ack !== 1'b1; t = t + 1)
        @(posedge clk);
      if (ack !== 1'b1) begin
        check(0, 1);
        end_of_test;
      end
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
    end
  endtask
  task frame(input integer n, input [7:0] h);
    integer t;
    begin
      wb(1, 4'h0, {8'h00, h, 4'h0, n[3:0], 8'h03});
      t = 0;
      q = 0;
      while (q[2] !== 1'b1 && t < 1000) begin
        wb(0, 4'h4, 0);
        t = t + 1;
      end
      if (q[2] !== 1'b1) begin
        check(0, 1);
        end_of_test;
      end
      check(q[2:0], 3'b110);
      for (t = 0; t <= n; t = t + 1) begin
        exp_ret = m1;
        m1 = m0;
        m0 = wv[t] & 16'h7FFF;
      end
      check(hold_a, m0);
      check(hold_b, m1);
      wb(0, 4'h8, 0);
      check(q[15:0], exp_ret);
      wb(0, 4'h0, 0);
      check(q, {8'h00, h, 4'h0, n[3:0], 8'h02});
    end
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    wb(0, 4'h4, 0);
    check({q[2:0], ref_a, ref_b, csn, sclk}, 7'h27);
    check(hold_a, 0);
    for (k = 0; k < 6; k = k + 1) begin
      for (i = 0; i < 2; i = i + 1) begin
        rnd = $random(seed);
        wv[i] = rnd[15:0];
        wb(1, 4'h8, {12'h000, i[3:0], wv[i]});
      end
      frame(k % 2, 8'h01 << (k % 3));
    end
    wb(1, 4'h0, 32'h00040000);
    repeat (2) @(posedge clk);
    check({ref_a, ref_b}, 2'b10);
    for (i = 0; i < 16; i = i + 1) begin
      wb(1, 4'hC, {27'h0, i[3], 1'b0, i[2:0]});
      repeat (2) @(posedge clk);
      check({g2, g1, g0, pd}, {i[2:0], i[3]});
    end
    // A start in parallel mode must leave the link idle
    wb(1, 4'h0, 32'h00040001);
    wb(0, 4'h4, 0);
    check(q[1:0], 2'b00);
    check(hold_a, m0);
    wb(0, 4'h2, 0);
    check(q, 0);
    // Half period of zero must saturate to one
    wb(1, 4'h0, 32'h00000002);
    repeat (2) @(posedge clk);
    check({ref_a, ref_b, g2, g1, g0, pd}, 6'h10);
    wb(0, 4'h0, 0);
    check(q, 32'h00010002);
    end_of_test;
  end
endmodule
